//--- burst_sram_pkg.sv
// shared constants and types for the flow-through burst static memory
// Notes on behaviour
// - builds as 256K x 36 with four lanes or 512K x 18 with two lanes
// - one loaded address yields up to four beats, counter makes the rest
// - first read beat flows from the array with no output register
// - with advance held low, three more beats follow on three edges
// - controller strobe loads address; processor strobe loads only when chip enable low
// - advance low steps the burst counter, advance high holds it
// - lane gate low lets lane selects act; high leaves only global write
// - lane k writes data bits 8k to 8k+7 plus parity bit k
// - any active lane write turns off all data drivers
// - global write low writes all lanes, overriding the lane selects
// - selected only with enable low, high select high, low select low
// - write data is registered on the edge; read data is not
// - order input high gives interleaved order, low gives linear order
// - output enable low drives data when selected; high floats the pins
// - sleep high freezes all clocked state; array contents are kept
// - array writes complete internally after the write cycle ends
package burst_sram_pkg;
  localparam int unsigned LANE_W = 9;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned WIDE_LANES = 4;
  localparam int unsigned NARROW_LANES = 2;
  localparam int unsigned WIDE_ADDR_W = 18;
  localparam int unsigned NARROW_ADDR_W = 19;
  localparam int unsigned BURST_BEATS = 4;
  localparam logic [1:0] BURST_CNT_RESET = 2'h0;
  localparam logic [1:0] BURST_CNT_STEP = 2'h1;
  localparam logic [1:0] BURST_CNT_LAST = 2'h3;

  typedef enum logic {
    order_linear,
    order_interleaved
  } burst_order_t;

  function automatic int unsigned addr_width(input int unsigned lanes);
    return (lanes == NARROW_LANES) ? NARROW_ADDR_W : WIDE_ADDR_W;
  endfunction
endpackage

//--- burst_order_gen.sv
// low address bits of a burst beat in linear or interleaved order
`timescale 1ns/100ps
module burst_order_gen (
  input wire logic [1:0] start_low,
  input wire logic [1:0] beat,
  input wire burst_sram_pkg::burst_order_t order,
  output logic [1:0] addr_low
);
  import burst_sram_pkg::*;

  always_comb begin
    if (order == order_interleaved) begin
      addr_low = start_low ^ beat;
    end else begin
      // two-bit sum wraps inside the aligned group of four
      addr_low = start_low + beat;
    end
  end
endmodule

//--- burst_sram.sv
// flow-through synchronous burst static memory core
`timescale 1ns/100ps
module burst_sram #(
  parameter int unsigned LANES = burst_sram_pkg::WIDE_LANES,
  parameter int unsigned AW = burst_sram_pkg::addr_width(LANES)
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [AW-1:0] addr,
  input wire logic ce_n,
  input wire logic select_high,
  input wire logic select_low_n,
  input wire logic controller_addr_strobe_n,
  input wire logic processor_addr_strobe_n,
  input wire logic burst_step_n,
  input wire logic all_lanes_write_n,
  input wire logic lane_write_gate_n,
  input wire logic lane0_write_sel_n,
  input wire logic lane1_write_sel_n,
  input wire logic lane2_write_sel_n,
  input wire logic lane3_write_sel_n,
  input wire logic output_enable_n,
  input wire logic burst_order_sel,
  input wire logic sleep_req,
  input wire logic [burst_sram_pkg::BYTE_W*LANES-1:0] data_in,
  output logic [burst_sram_pkg::BYTE_W*LANES-1:0] data_out,
  output logic data_oe,
  input wire logic [LANES-1:0] parity_data_bits_in,
  output logic [LANES-1:0] parity_data_bits_out,
  output logic parity_data_bits_oe
);
  import burst_sram_pkg::*;

  localparam int unsigned DEPTH = 1 << AW;
  localparam int unsigned WW = LANE_W * LANES;

  // registered address and burst state
  logic [AW-1:0] base_addr;
  logic [1:0] beat;
  logic [1:0] cur_low;
  logic active;

  // write input registers, drained into the array one edge later
  logic [AW-1:0] wr_addr;
  logic [WW-1:0] wr_word;
  logic [LANES-1:0] wr_lanes;

  // decode of the sampled control inputs
  logic chip_sel;
  logic load_c;
  logic load_p;
  logic load;
  logic step;
  logic proc_only;
  logic [AW-1:0] next_base;
  logic [1:0] next_beat;
  logic next_active;
  logic [1:0] next_low;
  logic [3:0] sel_n_all;
  logic [LANES-1:0] lane_req;
  logic [LANES-1:0] next_lanes;

  // datapath words, lane k is {parity bit k, byte k}
  logic [WW-1:0] in_word;
  logic [WW-1:0] rd_word;
  logic [AW-1:0] cur_addr;
  logic write_cycle;

  assign sel_n_all = {lane3_write_sel_n, lane2_write_sel_n, lane1_write_sel_n, lane0_write_sel_n};
  assign cur_addr = {base_addr[AW-1:2], cur_low};
  assign write_cycle = |wr_lanes;

  always_comb begin
    chip_sel = !ce_n && select_high && !select_low_n;
    load_c = !controller_addr_strobe_n;
    load_p = !processor_addr_strobe_n && !ce_n;
    load = load_c || load_p;
    proc_only = load_p && !load_c;
    step = !burst_step_n && active;
    next_base = base_addr;
    next_beat = beat;
    next_active = active;
    if (load) begin
      next_base = addr;
      next_beat = BURST_CNT_RESET;
      next_active = chip_sel;
    end else if (step) begin
      next_beat = beat + BURST_CNT_STEP;
    end
  end

  // order input is a strap, so it feeds the sequence without resampling
  burst_order_gen u_order (
    .start_low(next_base[1:0]),
    .beat(next_beat),
    .order(burst_order_t'(burst_order_sel)),
    .addr_low(next_low)
  );

  always_comb begin
    lane_req = '0;
    for (int i = 0; i < LANES; i++) begin
      lane_req[i] = !lane_write_gate_n && !sel_n_all[i];
    end
    if (!all_lanes_write_n) begin
      lane_req = '1;
    end
    // a load by the processor strobe alone is always a read; with the controller strobe also low it can write
    next_lanes = (next_active && !proc_only) ? lane_req : '0;
  end

  // address register and burst counter; sleep stops the internal clock
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      base_addr <= '0;
      beat <= BURST_CNT_RESET;
      cur_low <= 2'h0;
    end else if (!sleep_req) begin
      base_addr <= next_base;
      beat <= next_beat;
      cur_low <= next_low;
    end
  end

  // selection state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      active <= 1'b0;
    end else if (!sleep_req) begin
      active <= next_active;
    end
  end

  // write input register: data, lanes and target address on the edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_lanes <= '0;
      wr_addr <= '0;
      wr_word <= '0;
    end else if (!sleep_req) begin
      wr_lanes <= next_lanes;
      wr_addr <= {next_base[AW-1:2], next_low};
      wr_word <= in_word;
    end
  end

  for (genvar i = 0; i < LANES; i++) begin : g_lane
    logic [LANE_W-1:0] lane_mem [DEPTH];

    assign in_word[i*LANE_W +: LANE_W] = {parity_data_bits_in[i], data_in[i*BYTE_W +: BYTE_W]};

    // the array is written after the cycle, from the input registers
    always_ff @(posedge clk) begin
      if (!sleep_req && wr_lanes[i]) begin
        lane_mem[wr_addr] <= wr_word[i*LANE_W +: LANE_W];
      end
    end

    // flow-through: no register between array and pins
    assign rd_word[i*LANE_W +: LANE_W] = lane_mem[cur_addr];
    assign data_out[i*BYTE_W +: BYTE_W] = rd_word[i*LANE_W +: BYTE_W];
    assign parity_data_bits_out[i] = rd_word[i*LANE_W + BYTE_W];
  end

  // output enable is asynchronous by nature, so the drive term is not registered
  always_comb begin
    data_oe = !output_enable_n && active && !write_cycle && !sleep_req;
    parity_data_bits_oe = data_oe;
  end

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_ctrl_strobe_load: assert property (
    !sleep_req && !controller_addr_strobe_n
    |=> base_addr == $past(addr) && beat == BURST_CNT_RESET)
    else $error("controller strobe did not load the address");

  a_proc_strobe_gated: assert property (
    !sleep_req && controller_addr_strobe_n && !processor_addr_strobe_n && ce_n
    |=> base_addr == $past(base_addr))
    else $error("processor strobe loaded while chip enable was high");

  a_proc_strobe_load: assert property (
    !sleep_req && controller_addr_strobe_n && !processor_addr_strobe_n && !ce_n
    |=> base_addr == $past(addr) && !write_cycle)
    else $error("processor strobe with chip enable did not load as a read");

  a_counter_step: assert property (
    !sleep_req && !load && !burst_step_n && active
    |=> beat == $past(beat) + BURST_CNT_STEP && base_addr == $past(base_addr))
    else $error("advance low did not step the burst counter");

  a_counter_hold: assert property (
    !sleep_req && !load && burst_step_n
    ##1 burst_step_n && !load && !sleep_req
    |=> $stable(beat) && $stable(cur_addr))
    else $error("burst address moved while advance was high");

  a_order_seq: assert property (
    cur_low == (burst_order_sel ? (base_addr[1:0] ^ beat) : (base_addr[1:0] + beat)))
    else $error("burst address does not follow the selected order");

  a_burst_wrap: assert property (
    !sleep_req && !load && step
    |=> cur_addr[AW-1:2] == $past(cur_addr[AW-1:2]))
    else $error("burst counter disturbed upper address bits");

  sequence s_burst_start;
    !sleep_req && !controller_addr_strobe_n && chip_sel;
  endsequence

  sequence s_burst_steps;
    (!sleep_req && !load && !burst_step_n) [*3];
  endsequence

  a_four_beats: assert property (
    s_burst_start ##1 s_burst_steps
    |=> beat == BURST_CNT_LAST && active && cur_addr[AW-1:2] == $past(addr[AW-1:2], 4))
    else $error("four-beat burst did not reach its last beat");

  a_select_needed: assert property (
    !sleep_req && !controller_addr_strobe_n && !chip_sel |=> !active)
    else $error("load without full select left the chip selected");

  a_deselect_off: assert property (
    !sleep_req && !controller_addr_strobe_n && !chip_sel
    |=> !data_oe && !parity_data_bits_oe)
    else $error("data drivers still on in the cycle after a deselect");

  a_oe_high_off: assert property (
    output_enable_n || !active |-> !data_oe && !parity_data_bits_oe)
    else $error("data driven with output enable high or chip deselected");

  a_oe_low_on: assert property (
    !output_enable_n && active && !write_cycle && !sleep_req |-> data_oe)
    else $error("data not driven with output enable low while selected");

  a_write_blanks: assert property (
    write_cycle |-> !data_oe && !parity_data_bits_oe)
    else $error("data drivers on during a lane write");

  a_gate_blocks: assert property (
    !sleep_req && all_lanes_write_n && lane_write_gate_n |=> wr_lanes == '0)
    else $error("lane selects acted while the lane gate was high");

  a_lane_map: assert property (
    s_burst_start and (all_lanes_write_n && !lane_write_gate_n)
    |=> wr_lanes == ~$past(sel_n_all[LANES-1:0]))
    else $error("lane selects mapped to the wrong lanes");

  a_global_write: assert property (
    s_burst_start and !all_lanes_write_n |=> &wr_lanes)
    else $error("global write did not select every lane");

  a_input_capture: assert property (
    !sleep_req |=> wr_word == $past(in_word) && wr_addr == cur_addr)
    else $error("write data or address not captured on the edge");

  a_read_after_write: assert property (
    !sleep_req && &wr_lanes ##1 cur_addr == $past(wr_addr)
    |-> rd_word == $past(wr_word))
    else $error("array read does not return the word just written");

  a_sleep_holds: assert property (
    sleep_req |=> $stable(base_addr) && $stable(beat) && $stable(active) && $stable(wr_lanes))
    else $error("clocked state changed during sleep");

  a_sleep_quiet: assert property (
    sleep_req |-> !data_oe)
    else $error("data driven during sleep");

  a_step_idle: assert property (
    !sleep_req && !load && !active
    |=> $stable(beat) && $stable(base_addr))
    else $error("burst counter moved while deselected");

  a_proc_load_state: assert property (
    !sleep_req && !processor_addr_strobe_n && !ce_n
    |=> beat == BURST_CNT_RESET && active == $past(chip_sel))
    else $error("processor strobe load did not restart the burst");

  a_ctrl_select: assert property (
    !sleep_req && !controller_addr_strobe_n
    |=> active == $past(chip_sel))
    else $error("controller strobe load took the wrong selection");

  a_select_holds: assert property (
    !sleep_req && !load
    |=> $stable(active))
    else $error("selection changed without an address load");

  a_deselect_no_write: assert property (
    !sleep_req && load && !chip_sel
    |=> wr_lanes == '0)
    else $error("write queued by a deselecting load");

  a_no_write_req: assert property (
    !sleep_req && all_lanes_write_n && (lane_write_gate_n || &sel_n_all[LANES-1:0])
    |=> !write_cycle)
    else $error("write queued with no write request");

  a_load_addr: assert property (
    !sleep_req && load
    |=> cur_addr == $past(addr))
    else $error("first beat address differs from the loaded address");

  a_write_target: assert property (
    !sleep_req && !controller_addr_strobe_n && chip_sel && !all_lanes_write_n
    |=> wr_addr == $past(addr) && &wr_lanes && wr_word == $past(in_word))
    else $error("global write not queued at the loaded address");

  a_global_over_lanes: assert property (
    !sleep_req && !controller_addr_strobe_n && chip_sel && !all_lanes_write_n && !lane_write_gate_n
    |=> &wr_lanes)
    else $error("lane selects overrode the global write");

  a_linear_step: assert property (
    !sleep_req && step && !load && !burst_order_sel
    |=> cur_low == $past(cur_low) + BURST_CNT_STEP)
    else $error("linear burst did not advance by one");

  a_interleave_step: assert property (
    !sleep_req && step && !load && burst_order_sel
    |=> (cur_low ^ $past(cur_low)) == (beat ^ $past(beat)))
    else $error("interleaved burst left the exclusive-or sequence");

  a_sleep_read_held: assert property (
    sleep_req
    |=> $stable(rd_word) && $stable(cur_addr))
    else $error("array output changed during sleep");

  c_burst_read: cover property (
    (s_burst_start and (all_lanes_write_n && lane_write_gate_n)) ##1 s_burst_steps ##1 data_oe);

  c_global_write: cover property (
    (s_burst_start and !all_lanes_write_n) ##1 write_cycle);

  c_lane_write: cover property (
    (s_burst_start and (all_lanes_write_n && !lane_write_gate_n && !lane0_write_sel_n)) ##1 wr_lanes[0]);

  c_deselect: cover property (
    active ##1 !sleep_req && !controller_addr_strobe_n && !chip_sel ##1 !active);

  c_sleep_retain: cover property (
    active ##1 sleep_req [*3] ##1 !sleep_req && data_oe);
endmodule

//--- host_ctrl.sv
// far-side cache controller model driving the memory's synchronous pins
`timescale 1ns/100ps
module host_ctrl (
  input wire logic clk,
  output logic [17:0] addr,
  output logic [7:0] ctl,
  output logic [3:0] lane_sel_n,
  output logic [35:0] wdata,
  output logic order
);
  logic wr;

  initial begin
    addr = 18'h0;
    ctl = 8'h5f;
    lane_sel_n = 4'hf;
    wdata = 36'h0;
    order = 1'b0;
    wr = 1'b0;
  end

  // the order strap only moves while the memory is held in reset
  task automatic strap(input logic o);
    @(posedge clk);
    order <= o;
  endtask

  // ctl is {ce_n, select_high, select_low_n, ctrl strobe, proc strobe, step, all write, lane gate}
  task automatic cyc(input logic [17:0] a, input logic [7:0] c, input logic [3:0] s, input logic [35:0] d);
    @(posedge clk);
    wr = !c[1] || (!c[0] && s != 4'hf);
    addr <= a;
    ctl <= c;
    lane_sel_n <= s;
    // released data lines toggle so stale write data can never pass for a capture
    wdata <= wr ? d : ~wdata;
    #5;
  endtask
endmodule

//--- tb_burst_sync_sram_flow_through.sv
// self-checking bench for the flow-through burst static memory
`timescale 1ns/100ps
module tb_burst_sync_sram_flow_through;
  localparam logic [17:0] BASE = 18'h00100;
  localparam logic [7:0] IDLE = 8'h5f;
  localparam logic [7:0] RD = 8'h4f;
  localparam logic [7:0] GWR = 8'h4d;
  localparam logic [7:0] STEP = 8'h5b;
  logic clk;
  logic sys_rst;
  logic output_enable_n;
  logic sleep_req;
  logic [17:0] addr;
  logic [7:0] ctl;
  logic [3:0] sel_n;
  logic [35:0] wdata;
  logic order;
  logic [31:0] data_out;
  logic [3:0] par_out;
  logic data_oe;
  logic par_oe;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;

  host_ctrl u_host (.clk(clk), .addr(addr), .ctl(ctl), .lane_sel_n(sel_n), .wdata(wdata), .order(order));

  burst_sram #(.LANES(4)) u_burst_sram (
    .clk(clk), .sys_rst(sys_rst), .addr(addr), .ce_n(ctl[7]), .select_high(ctl[6]), .select_low_n(ctl[5]),
    .controller_addr_strobe_n(ctl[4]), .processor_addr_strobe_n(ctl[3]), .burst_step_n(ctl[2]),
    .all_lanes_write_n(ctl[1]), .lane_write_gate_n(ctl[0]), .lane0_write_sel_n(sel_n[0]),
    .lane1_write_sel_n(sel_n[1]), .lane2_write_sel_n(sel_n[2]), .lane3_write_sel_n(sel_n[3]),
    .output_enable_n(output_enable_n), .burst_order_sel(order), .sleep_req(sleep_req),
    .data_in(wdata[31:0]), .data_out(data_out), .data_oe(data_oe), .parity_data_bits_in(wdata[35:32]),
    .parity_data_bits_out(par_out), .parity_data_bits_oe(par_oe));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // the whole run needs under a hundred cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      miscompares = miscompares + 1;
      complete_run();
    end
  end

  function automatic logic [35:0] pat(input logic [17:0] a);
    return {a[3:0] ^ 4'h5, ~a[13:0], a};
  endfunction

  task automatic chk_d(input logic [35:0] exp);
    comparisons++;
    if ({par_out, data_out} !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t data got %h exp %h", $time, {par_out, data_out}, exp);
    end
  endtask

  task automatic chk_oe(input logic exp);
    comparisons++;
    if ({par_oe, data_oe} !== {exp, exp}) begin
      miscompares++;
      $display("[FAIL] t=%0t drive got %h exp %h", $time, {par_oe, data_oe}, {exp, exp});
    end
  endtask

  task automatic restart(input logic o);
    @(posedge clk);
    sys_rst <= 1'b1;
    u_host.strap(o);
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
  endtask

  task automatic t_burst(input logic o);
    int b;
    logic [1:0] lo;
    restart(o);
    for (int i = 0; i < 4; i++) begin
      u_host.cyc(BASE + 18'(i), GWR, 4'hf, pat(BASE + 18'(i)));
      chk_oe(1'b0);
    end
    u_host.cyc(BASE + 18'h1, RD, 4'hf, 36'h0);
    chk_oe(1'b0);
    for (int k = 0; k < 5; k++) begin
      u_host.cyc(BASE, (k < 3) ? STEP : IDLE, 4'hf, 36'h0);
      b = (k > 3) ? 3 : k;
      lo = o ? (2'h1 ^ 2'(b)) : (2'h1 + 2'(b));
      chk_d(pat({BASE[17:2], lo}));
      chk_oe(1'b1);
    end
  endtask

  task automatic t_lanes();
    logic [35:0] exp;
    exp = pat(BASE) ^ 36'h4_00ff_0000;
    u_host.cyc(BASE, 8'h4e, 4'b1011, ~pat(BASE));
    u_host.cyc(BASE, RD, 4'h0, ~pat(BASE));
    chk_oe(1'b0);
    u_host.cyc(BASE, IDLE, 4'hf, 36'h0);
    chk_oe(1'b1);
    chk_d(exp);
    u_host.cyc(BASE, 8'h4c, 4'he, 36'h9_1234_5678);
    u_host.cyc(BASE, IDLE, 4'hf, 36'h0);
    chk_oe(1'b0);
    u_host.cyc(BASE, IDLE, 4'hf, 36'h0);
    chk_d(36'h9_1234_5678);
  endtask

  task automatic t_select();
    logic [7:0] off [3];
    off = '{8'hcf, 8'h0f, 8'h6f};
    foreach (off[i]) begin
      u_host.cyc(BASE + 18'h2, RD, 4'hf, 36'h0);
      u_host.cyc(BASE, off[i], 4'hf, 36'h0);
      chk_oe(1'b1);
      u_host.cyc(BASE, IDLE, 4'hf, 36'h0);
      chk_oe(1'b0);
    end
    u_host.cyc(BASE + 18'h2, RD, 4'hf, 36'h0);
    u_host.cyc(BASE + 18'h3, 8'hd7, 4'hf, 36'h0);
    u_host.cyc(BASE, IDLE, 4'hf, 36'h0);
    chk_d(pat(BASE + 18'h2));
    u_host.cyc(BASE + 18'h3, 8'h57, 4'hf, 36'h0);
    u_host.cyc(BASE, IDLE, 4'hf, 36'h0);
    chk_d(pat(BASE + 18'h3));
    chk_oe(1'b1);
  endtask

  task automatic t_oe_sleep();
    @(posedge clk);
    output_enable_n <= 1'b1;
    #1;
    chk_oe(1'b0);
    @(posedge clk);
    output_enable_n <= 1'b0;
    #1;
    chk_oe(1'b1);
    @(posedge clk);
    sleep_req <= 1'b1;
    u_host.cyc(BASE + 18'h2, RD, 4'hf, 36'h0);
    chk_oe(1'b0);
    u_host.cyc(BASE, IDLE, 4'hf, 36'h0);
    @(posedge clk);
    sleep_req <= 1'b0;
    u_host.cyc(BASE, IDLE, 4'hf, 36'h0);
    chk_d(pat(BASE + 18'h3));
    chk_oe(1'b1);
  endtask

  task automatic complete_run();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    sys_rst = 1'b1;
    output_enable_n = 1'b0;
    sleep_req = 1'b0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    t_burst(1'b0);
    t_burst(1'b1);
    t_lanes();
    t_select();
    t_oe_sleep();
    complete_run();
  end
endmodule
